// ### inc/bch_pkg.sv
// Constants, register layout and state codes of the bus cycle handshake block.
// Assumes a single system clock; imported by both design modules of the block.
package bch_pkg;
  // Register offsets, byte addresses on the plain register port
  localparam logic [7:0] BCH_OFF_CFG   = 8'h00;
  localparam logic [7:0] BCH_OFF_STAT  = 8'h04;
  localparam logic [7:0] BCH_OFF_MASK  = 8'h08;
  localparam logic [7:0] BCH_OFF_STATE = 8'h0C;

  // Configuration fields
  localparam int BCH_CFG_LBR_POS  = 0;
  localparam int BCH_CFG_SYNCHRONOUS_BUS_BIT_POS = 1;
  localparam logic [1:0] BCH_CFG_RST = 2'h0;

  // Status and mask fields
  localparam int BCH_ST_RETRY_POS = 0;
  localparam int BCH_ST_DMA_POS   = 1;
  localparam int BCH_ST_SLV_POS   = 2;
  localparam int BCH_ST_W         = 3;
  localparam logic [2:0] BCH_ST_RST   = 3'h0;
  localparam logic [2:0] BCH_MASK_RST = 3'h0;

  // Sampled input lanes
  localparam int BCH_SMP_ACKL  = 0;
  localparam int BCH_SMP_ACKH  = 1;
  localparam int BCH_SMP_RDY   = 2;
  localparam int BCH_SMP_RETRY = 3;
  localparam int BCH_SMP_W     = 4;
  localparam logic [3:0] BCH_SMP_IDLE = 4'hF;

  // Bus mode values
  localparam logic BCH_MODE_READY = 1'b0;
  localparam logic BCH_MODE_ACK   = 1'b1;

  // Master cycle states
  typedef enum logic [3:0] {
    BCH_IDLE  = 4'b0001,
    BCH_T1    = 4'b0010,
    BCH_T2    = 4'b0100,
    BCH_RETRY = 4'b1000
  } bch_state_t;
endpackage

// ### inc/bch_smp_if.sv
// Carrier between the top module and its input sampler.
// Assumes raw pins are active low and idle high.
`timescale 1ns/1ps
interface bch_smp_if #(
  parameter int W = 4
);
  logic [W-1:0] raw;
  logic [W-1:0] smp;
  logic         sync_mode;

  modport top     (output raw, output sync_mode, input smp);
  modport sampler (input raw, input sync_mode, output smp);
endinterface

// ### logic/bch_sampler.sv
// Input sampler for acknowledge, ready and retry pins.
// Assumes the raw pins idle high; sync mode takes one flop, async two.
`timescale 1ns/1ps
module bch_sampler
  import bch_pkg::*;
#(
  parameter int W = 4
)(
  input  wire logic   i_clk_sys,
  input  wire logic   i_sys_rst,
  bch_smp_if.sampler  smp_if
);
  logic [W-1:0] sync_reg;
  logic [W-1:0] meta_reg;
  logic [W-1:0] async_reg;

  // Single stage for inputs already synchronous to the bus clock
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      sync_reg <= {W{1'b1}};
    else
      sync_reg <= smp_if.raw;
  end

  // Two stage chain; the first stage feeds only the second
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      meta_reg  <= {W{1'b1}};
      async_reg <= {W{1'b1}};
    end
    else
    begin
      meta_reg  <= smp_if.raw;
      async_reg <= meta_reg;
    end
  end

  // Async mode costs one extra cycle of latency for safety
  assign smp_if.smp = smp_if.sync_mode ? sync_reg : async_reg;
endmodule

// ### logic/bch_bus_ctrl.sv
// Bus cycle handshake: master cycles with strobe, acknowledge, retry and
// early cycle start; slave cycle end; shared memory arbitration.
// Assumes pins other than ack, ready and retry are synchronous to i_clk_sys; tristate resolved outside.
`timescale 1ns/1ps
module bch_bus_ctrl
  import bch_pkg::*;
#(
  parameter int AW = 23,
  parameter int DW = 16
)(
  input  wire logic          i_clk_sys,
  input  wire logic          i_sys_rst,
  // Register port
  input  wire logic [7:0]    i_reg_addr,
  input  wire logic [15:0]   i_reg_wdata,
  input  wire logic          i_reg_wr,
  input  wire logic          i_reg_rd,
  output logic [15:0]        o_reg_rdata,
  output logic               o_irq,
  // Internal DMA request side
  input  wire logic          i_bus_owned,
  input  wire logic          i_dma_req,
  input  wire logic          i_dma_write,
  input  wire logic [AW-1:0] i_dma_addr,
  input  wire logic [DW-1:0] i_dma_wdata,
  output logic               o_dma_done,
  output logic [DW-1:0]      o_dma_rdata,
  output logic               o_dma_suspended,
  // Register slave side towards the register core
  output logic               o_host_req,
  output logic               o_host_read,
  output logic [5:0]         o_host_addr,
  output logic [DW-1:0]      o_host_wdata,
  input  wire logic          i_host_done,
  input  wire logic [DW-1:0] i_host_rdata,
  output logic               o_mem_host_grant,
  // System bus pins
  input  wire logic          i_bus_mode_input,
  output logic [AW-1:0]      o_addr,
  output logic               o_addr_oe_n,
  input  wire logic [DW-1:0] i_data,
  output logic [DW-1:0]      o_data,
  output logic               o_data_oe_n,
  output logic               o_master_data_strobe_n,
  output logic               o_master_data_strobe_oe_n,
  output logic               o_early_cycle_start_n,
  output logic               o_early_cycle_start_oe_n,
  output logic               o_master_write,
  input  wire logic          i_size_ack_low_n,
  output logic               o_size_ack_low_n,
  output logic               o_size_ack_low_oe_n,
  input  wire logic          i_size_ack_high_n,
  output logic               o_size_ack_high_n,
  output logic               o_size_ack_high_oe_n,
  input  wire logic          i_ready_input_pin_n,
  output logic               o_ready_output_pin_n,
  output logic               o_ready_output_pin_oe_n,
  input  wire logic          i_bus_retry_n,
  input  wire logic          i_reg_select_n,
  input  wire logic [5:0]    i_reg_addr_pins,
  input  wire logic          i_slave_ds_n,
  input  wire logic          i_slave_rw,
  input  wire logic          i_memory_request_n,
  output logic               o_shared_acknowledge_n
);
  // Byte lane swap for big endian ordering
  function automatic logic [DW-1:0] bch_order(input logic [DW-1:0] d, input logic big);
    bch_order = big ? {d[7:0], d[DW-1:8]} : d;
  endfunction

  bch_smp_if #(.W(BCH_SMP_W)) smp_if ();
  bch_state_t             state_reg;
  logic [1:0]             cfg_reg;
  logic [BCH_ST_W-1:0]    stat_reg;
  logic [BCH_ST_W-1:0]    mask_reg;
  logic                   mode_reg;
  logic                   wr_reg;
  logic [DW-1:0]          wdata_reg;
  logic                   slv_done_reg;
  logic                   slv_pend_reg;
  logic                   mem_grant_reg;
  logic                   blocked;
  logic                   cycle_end;
  logic                   slv_active;
  logic                   slv_read;
  logic [BCH_ST_W-1:0]    st_set;
  logic [BCH_ST_W-1:0]    st_clr;

  // Raw inputs to the sampler; sync flag from configuration
  assign smp_if.raw       = {i_bus_retry_n, i_ready_input_pin_n,
                             i_size_ack_high_n, i_size_ack_low_n};
  assign smp_if.sync_mode = cfg_reg[BCH_CFG_SYNCHRONOUS_BUS_BIT_POS];

  bch_sampler #(.W(BCH_SMP_W)) u_sampler (
    .i_clk_sys (i_clk_sys),
    .i_sys_rst (i_sys_rst),
    .smp_if    (smp_if)
  );

  // Bus mode pin taken every cycle, it chooses protocol and byte order
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      mode_reg <= BCH_MODE_READY;
    else
      mode_reg <= i_bus_mode_input;
  end

  // Any size ack asserted ends the cycle; encoding is ignored
  always_comb
  begin
    if (mode_reg == BCH_MODE_ACK)
      cycle_end = !smp_if.smp[BCH_SMP_ACKL] || !smp_if.smp[BCH_SMP_ACKH];
    else
      cycle_end = !smp_if.smp[BCH_SMP_RDY];
  end

  // A latched retry holds off new DMA until status is cleared
  assign blocked = cfg_reg[BCH_CFG_LBR_POS] && stat_reg[BCH_ST_RETRY_POS];
  assign o_dma_suspended = blocked;

  // Master cycle sequencer; no start while done shows, so a late drop is no rerun
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      state_reg <= BCH_IDLE;
    else if (!i_bus_owned)
      state_reg <= BCH_IDLE;
    else
    begin
      case (state_reg)
        BCH_IDLE:
          if (i_dma_req && !blocked && !mem_grant_reg && !o_dma_done)
            state_reg <= BCH_T1;
        BCH_T1:
          state_reg <= BCH_T2;
        BCH_T2:
          if (!smp_if.smp[BCH_SMP_RETRY])
            state_reg <= BCH_RETRY;
          else if (cycle_end)
            state_reg <= BCH_IDLE;
        BCH_RETRY:
          if (smp_if.smp[BCH_SMP_RETRY])
            state_reg <= BCH_T1;
        default:
          state_reg <= BCH_IDLE;
      endcase
    end
  end

  // Cycle attributes held from the start of the first state
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      wr_reg    <= 1'b0;
      wdata_reg <= '0;
      o_addr    <= '0;
    end
    else if (state_reg == BCH_IDLE && i_dma_req)
    begin
      wr_reg    <= i_dma_write;
      wdata_reg <= bch_order(i_dma_wdata, mode_reg);
      o_addr    <= i_dma_addr;
    end
  end

  // Completion pulse and read data capture
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      o_dma_done  <= 1'b0;
      o_dma_rdata <= '0;
    end
    else
    begin
      o_dma_done <= i_bus_owned && state_reg == BCH_T2 && smp_if.smp[BCH_SMP_RETRY]
                    && cycle_end;
      if (state_reg == BCH_T2 && cycle_end && !wr_reg)
        o_dma_rdata <= bch_order(i_data, mode_reg);
    end
  end

  // Strobe low in the data state only; strobe, address and early start float without the bus, write stays driven
  assign o_master_data_strobe_n    = !(state_reg == BCH_T2);
  assign o_master_data_strobe_oe_n = !i_bus_owned;
  assign o_addr_oe_n               = !i_bus_owned;
  assign o_master_write            = wr_reg;
  assign o_early_cycle_start_oe_n  = !i_bus_owned;
  // High clock phase of the first state; follows the clock on purpose
  assign o_early_cycle_start_n     = !(state_reg == BCH_T1 && i_clk_sys);

  // Slave cycle decode; read polarity flips with bus mode
  assign slv_read   = (mode_reg == BCH_MODE_ACK) ? i_slave_rw : !i_slave_rw;
  assign slv_active = !i_reg_select_n && !i_slave_ds_n;

  // Slave request held until the core answers, then done until release
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      slv_pend_reg <= 1'b0;
      slv_done_reg <= 1'b0;
      o_host_read  <= 1'b0;
      o_host_addr  <= '0;
      o_host_wdata <= '0;
    end
    else if (!slv_active)
    begin
      slv_pend_reg <= 1'b0;
      slv_done_reg <= 1'b0;
    end
    else if (!slv_pend_reg && !slv_done_reg)
    begin
      slv_pend_reg <= 1'b1;
      o_host_read  <= slv_read;
      o_host_addr  <= i_reg_addr_pins;
      o_host_wdata <= bch_order(i_data, mode_reg);
    end
    else if (slv_pend_reg && i_host_done)
    begin
      slv_pend_reg <= 1'b0;
      slv_done_reg <= 1'b1;
    end
  end
  assign o_host_req = slv_pend_reg;

  // Read data for the slave or write data for the master, on all 16 lines
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_data <= '0;
    else if (slv_pend_reg && i_host_done)
      o_data <= bch_order(i_host_rdata, mode_reg);
    else if (state_reg == BCH_T1)
      o_data <= wdata_reg;
  end
  assign o_data_oe_n = !((slv_done_reg && o_host_read)
                         || (i_bus_owned && wr_reg && state_reg != BCH_IDLE));

  // Ack mode: both size acks low ends the slave cycle, a 32-bit answer
  assign o_size_ack_low_n     = !slv_done_reg;
  assign o_size_ack_high_n    = !slv_done_reg;
  assign o_size_ack_low_oe_n  = !(mode_reg == BCH_MODE_ACK && !i_reg_select_n);
  assign o_size_ack_high_oe_n = !(mode_reg == BCH_MODE_ACK && !i_reg_select_n);
  // Ready mode: ready output ends the slave cycle
  assign o_ready_output_pin_n    = !slv_done_reg;
  assign o_ready_output_pin_oe_n = !(mode_reg == BCH_MODE_READY && !i_reg_select_n);

  // Host memory grant only between master cycles, held while requested
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      mem_grant_reg <= 1'b0;
    else if (i_memory_request_n)
      mem_grant_reg <= 1'b0;
    else if (state_reg == BCH_IDLE && !(i_bus_owned && i_dma_req && !blocked))
      mem_grant_reg <= 1'b1;
  end
  assign o_mem_host_grant = mem_grant_reg;
  // Select and request never overlap, so one pin serves both
  assign o_shared_acknowledge_n = !(slv_done_reg || mem_grant_reg);

  // Sticky events; set beats a same-cycle clear
  assign st_set[BCH_ST_RETRY_POS] = state_reg == BCH_T2 && !smp_if.smp[BCH_SMP_RETRY];
  assign st_set[BCH_ST_DMA_POS]   = o_dma_done;
  assign st_set[BCH_ST_SLV_POS]   = slv_pend_reg && i_host_done;
  assign st_clr = (i_reg_wr && i_reg_addr == BCH_OFF_STAT) ? i_reg_wdata[BCH_ST_W-1:0] : '0;

  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      stat_reg <= BCH_ST_RST;
    else
      stat_reg <= (stat_reg & ~st_clr) | st_set;
  end

  // Configuration and mask writes
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
    begin
      cfg_reg  <= BCH_CFG_RST;
      mask_reg <= BCH_MASK_RST;
    end
    else if (i_reg_wr)
    begin
      if (i_reg_addr == BCH_OFF_CFG)
        cfg_reg <= i_reg_wdata[1:0];
      else if (i_reg_addr == BCH_OFF_MASK)
        mask_reg <= i_reg_wdata[BCH_ST_W-1:0];
    end
  end

  // Read data one cycle after the strobe; unmapped reads give zero
  always_ff @(posedge i_clk_sys or posedge i_sys_rst)
  begin
    if (i_sys_rst)
      o_reg_rdata <= 16'h0000;
    else if (!i_reg_rd)
      o_reg_rdata <= 16'h0000;
    else if (i_reg_addr == BCH_OFF_CFG)
      o_reg_rdata <= {14'h0000, cfg_reg};
    else if (i_reg_addr == BCH_OFF_STAT)
      o_reg_rdata <= {13'h0000, stat_reg};
    else if (i_reg_addr == BCH_OFF_MASK)
      o_reg_rdata <= {13'h0000, mask_reg};
    else if (i_reg_addr == BCH_OFF_STATE)
      o_reg_rdata <= {10'h000, mem_grant_reg, blocked, state_reg};
    else
      o_reg_rdata <= 16'h0000;
  end

  assign o_irq = |(stat_reg & mask_reg);
endmodule

// ### tb/bch_chk.sv
// Port-level assertions for the bus cycle handshake block.
// Assumes bus mode and sync setting only change while the bus is quiet.
`timescale 1ns/1ps
module bch_chk (
  input wire logic i_clk_sys,
  input wire logic i_sys_rst,
  input wire logic i_bus_owned,
  input wire logic i_bus_mode_input,
  input wire logic i_size_ack_low_n,
  input wire logic i_size_ack_high_n,
  input wire logic i_ready_input_pin_n,
  input wire logic i_bus_retry_n,
  input wire logic i_host_done,
  input wire logic i_reg_select_n,
  input wire logic i_slave_ds_n,
  input wire logic i_memory_request_n,
  input wire logic o_master_data_strobe_n,
  input wire logic o_master_data_strobe_oe_n,
  input wire logic o_early_cycle_start_n,
  input wire logic o_dma_done,
  input wire logic o_dma_suspended,
  input wire logic o_size_ack_low_n,
  input wire logic o_size_ack_high_n,
  input wire logic o_size_ack_low_oe_n,
  input wire logic o_size_ack_high_oe_n,
  input wire logic o_ready_output_pin_n,
  input wire logic o_ready_output_pin_oe_n,
  input wire logic o_shared_acknowledge_n,
  input wire logic o_mem_host_grant
);
  logic ack_seen;
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (i_sys_rst);
  // Termination input of the mode in use, any size code counts
  assign ack_seen = i_bus_mode_input ? !(i_size_ack_low_n && i_size_ack_high_n)
                                     : !i_ready_input_pin_n;
  done_after_ack_a: assert property (o_dma_done |-> $past(ack_seen, 2)
    && !$past(o_master_data_strobe_n)) else $error("done without strobe and ack");
  strobe_float_a: assert property (!i_bus_owned && !$past(i_bus_owned)
    |-> o_master_data_strobe_oe_n) else $error("strobe driven without bus");
  ecs_low_phase_a: assert property (o_early_cycle_start_n)
    else $error("early start low in low clock phase");
  ecs_then_strobe_a: assert property (@(negedge i_clk_sys) disable iff (i_sys_rst)
    !o_early_cycle_start_n |-> o_master_data_strobe_n ##1
    (!o_master_data_strobe_n || !i_bus_owned)) else $error("early start not followed by strobe");
  retry_ends_a: assert property (!i_bus_retry_n && !o_master_data_strobe_n
    |-> ##[1:4] (o_master_data_strobe_n && !o_dma_done)) else $error("retry did not end cycle");
  suspend_hold_a: assert property (o_dma_done && o_dma_suspended ##1 o_dma_suspended
    ##1 o_dma_suspended |-> o_master_data_strobe_n) else $error("cycle while suspended");
  slave_end_a: assert property (i_host_done && !i_reg_select_n && !i_slave_ds_n
    |=> !o_shared_acknowledge_n && (i_bus_mode_input ?
    (!o_size_ack_low_n && !o_size_ack_low_oe_n)
    : (!o_ready_output_pin_n && !o_ready_output_pin_oe_n))) else $error("slave cycle not ended");
  ack_pair_a: assert property (!o_size_ack_low_oe_n |-> !o_size_ack_high_oe_n
    && o_size_ack_low_n == o_size_ack_high_n) else $error("size acks differ");
  mode_pins_a: assert property ($stable(i_bus_mode_input) && !i_bus_mode_input
    |-> o_size_ack_low_oe_n && o_size_ack_high_oe_n) else $error("acks driven in ready mode");
  grant_excl_a: assert property (o_mem_host_grant |-> !o_shared_acknowledge_n
    && o_master_data_strobe_n && !$past(i_memory_request_n)) else $error("bad grant");
endmodule

bind bch_bus_ctrl bch_chk chk_u (
  .i_clk_sys(i_clk_sys), .i_sys_rst(i_sys_rst), .i_bus_owned(i_bus_owned),
  .i_bus_mode_input(i_bus_mode_input), .i_size_ack_low_n(i_size_ack_low_n),
  .i_size_ack_high_n(i_size_ack_high_n), .i_ready_input_pin_n(i_ready_input_pin_n),
  .i_bus_retry_n(i_bus_retry_n), .i_host_done(i_host_done),
  .i_reg_select_n(i_reg_select_n), .i_slave_ds_n(i_slave_ds_n),
  .i_memory_request_n(i_memory_request_n), .o_master_data_strobe_n(o_master_data_strobe_n),
  .o_master_data_strobe_oe_n(o_master_data_strobe_oe_n),
  .o_early_cycle_start_n(o_early_cycle_start_n), .o_dma_done(o_dma_done),
  .o_dma_suspended(o_dma_suspended), .o_size_ack_low_n(o_size_ack_low_n),
  .o_size_ack_high_n(o_size_ack_high_n), .o_size_ack_low_oe_n(o_size_ack_low_oe_n),
  .o_size_ack_high_oe_n(o_size_ack_high_oe_n), .o_ready_output_pin_n(o_ready_output_pin_n),
  .o_ready_output_pin_oe_n(o_ready_output_pin_oe_n),
  .o_shared_acknowledge_n(o_shared_acknowledge_n), .o_mem_host_grant(o_mem_host_grant)
);

// ### tb/bch_sys_model.sv
// Behavioural system bus slave answering the block's master cycles.
// Assumes ack and retry lines are pulled up; data always drives, the read pattern only on reads.
`timescale 1ns/1ps
module bch_sys_model #(
  parameter logic [15:0] RD = 16'hA5C3
)(
  input  wire logic        i_clk_sys,
  input  wire logic        i_strobe_n,
  input  wire logic        i_write,
  input  wire logic        i_mode,
  input  wire logic [15:0] i_bus_data,
  input  wire logic [1:0]  i_waits,
  input  wire logic [1:0]  i_code,
  input  wire logic        i_arm_retry,
  output logic             o_ack_low_n,
  output logic             o_ack_high_n,
  output logic             o_ready_n,
  output logic             o_retry_n,
  output logic [15:0]      o_data,
  output logic [15:0]      o_seen
);
  logic [3:0] cnt;
  logic       used;
  // Held data only while strobe asks for it, inverse pattern otherwise
  assign o_data = (!i_strobe_n && !i_write) ? RD : ~RD;
  // Waits, then answers; everything released once strobe rises
  always @(posedge i_clk_sys)
  begin
    if (!i_arm_retry) used <= 1'b0;
    if (i_strobe_n) begin cnt <= 4'h0; o_ack_low_n <= 1'b1; o_ack_high_n <= 1'b1;
      o_ready_n <= 1'b1; o_retry_n <= 1'b1; end
    else begin
      cnt <= cnt + 4'h1;
      if (i_write) o_seen <= i_bus_data;
      if (cnt == {2'h0, i_waits} && i_arm_retry && !used)
      begin
        o_retry_n <= 1'b0;
        used <= 1'b1;
      end
      else if (cnt == {2'h0, i_waits} && o_retry_n)
      begin
        o_ack_low_n <= !(i_mode && i_code[0]);
        o_ack_high_n <= !(i_mode && i_code[1]);
        o_ready_n <= i_mode;
      end
    end
  end
endmodule

// ### tb/tb_bus_cycle_handshake.sv
// Random and corner tests of the bus cycle handshake block.
// Assumes the system bus slave model and the bound checker.
`timescale 1ns/1ps
`define CHK(a, b) begin n_compared++; if ((a) !== (b)) begin err_count++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, a, b); end end
module tb_bus_cycle_handshake;
  import bch_pkg::*;
  logic clk = 0, rst = 1, wr = 0, rd = 0, own = 1, dreq = 0, dwr = 0, hdone = 0, mode = 0;
  logic sel_n = 1, ds_n = 1, rw = 0, memory_request_n = 1, arm = 0;
  logic [7:0] addr = 8'h00;
  logic [15:0] wd = 16'h0, dwd = 16'h0, hrd = 16'h0, q, exp;
  logic [22:0] dad = 23'h0;
  logic [22:0] oaddr;
  logic mwr, aoe, rdy_o;
  logic [5:0] ra = 6'h0;
  logic [1:0] waits = 2'h0, code = 2'h1;
  logic ackl, ackh, rdy, rty, done, susp, req, grant, irq, shared_acknowledge, strobe, oe, ackl_o;
  logic [15:0] rdata, odata, mdata, seen, drd, hwd;
  logic [5:0] haddr;
  logic hread;
  wire [15:0] bus = !oe ? odata : mdata;
  integer seed = 32'hF9A3, err_count = 0, n_compared = 0, i, k;
  bch_bus_ctrl dut_u (.i_clk_sys(clk), .i_sys_rst(rst), .i_reg_addr(addr), .i_reg_wdata(wd),
    .i_reg_wr(wr), .i_reg_rd(rd), .o_reg_rdata(rdata), .o_irq(irq), .i_bus_owned(own),
    .i_dma_req(dreq), .i_dma_write(dwr), .i_dma_addr(dad), .i_dma_wdata(dwd),
    .o_dma_done(done), .o_dma_rdata(drd), .o_dma_suspended(susp), .o_host_req(req),
    .o_host_read(hread), .o_host_addr(haddr), .o_host_wdata(hwd), .i_host_done(hdone),
    .i_host_rdata(hrd), .o_mem_host_grant(grant), .i_bus_mode_input(mode), .o_addr(oaddr),
    .o_addr_oe_n(aoe), .i_data(bus), .o_data(odata), .o_data_oe_n(oe),
    .o_master_data_strobe_n(strobe), .o_master_data_strobe_oe_n(),
    .o_early_cycle_start_n(), .o_early_cycle_start_oe_n(), .o_master_write(mwr),
    .i_size_ack_low_n(ackl), .o_size_ack_low_n(ackl_o), .o_size_ack_low_oe_n(),
    .i_size_ack_high_n(ackh), .o_size_ack_high_n(), .o_size_ack_high_oe_n(),
    .i_ready_input_pin_n(rdy), .o_ready_output_pin_n(rdy_o), .o_ready_output_pin_oe_n(),
    .i_bus_retry_n(rty), .i_reg_select_n(sel_n), .i_reg_addr_pins(ra), .i_slave_ds_n(ds_n),
    .i_slave_rw(rw), .i_memory_request_n(memory_request_n), .o_shared_acknowledge_n(shared_acknowledge));
  bch_sys_model mdl_u (.i_clk_sys(clk), .i_strobe_n(strobe), .i_write(mwr), .i_mode(mode),
    .i_bus_data(bus), .i_waits(waits), .i_code(code), .i_arm_retry(arm), .o_ack_low_n(ackl),
    .o_ack_high_n(ackh), .o_ready_n(rdy), .o_retry_n(rty), .o_data(mdata), .o_seen(seen));
  // Free-running bus clock, 50 ns
  initial forever #25 clk = ~clk;
  function automatic logic [15:0] order(input logic [15:0] v);
    order = mode ? {v[7:0], v[15:8]} : v;
  endfunction
  task give_verdict;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task reg_wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk); wr <= 1; addr <= a; wd <= d; @(posedge clk); wr <= 0;
  endtask
  task reg_rd(input logic [7:0] a);
    @(posedge clk); rd <= 1; addr <= a; @(posedge clk); rd <= 0; @(negedge clk); q = rdata;
  endtask
  task wait_on(input logic which);
    for (k = 0; k < 80; k++) begin @(negedge clk); if ((which ? req : done) === 1'b1) break; end
    if (k == 80) begin err_count++; give_verdict; end
    else if (!which) begin @(posedge clk); dreq <= 0; end
  endtask
  task dma(input logic w);
    @(posedge clk); dreq <= 1; dwr <= w; dwd <= 16'($random(seed)); dad <= 23'($random(seed));
    waits <= 2'($random(seed)); code <= 2'h1 + 2'({$random(seed)} % 3);
    wait_on(0);
  endtask
  // Reset, register defaults and an unmapped read
  initial
  begin
    repeat (20) @(posedge clk);
    rst <= 0;
    for (i = 0; i < 5; i++)
    begin
      reg_rd(8'h00 + 8'(i * 4));
      `CHK(q, (i == 3) ? 16'h0001 : 16'h0000)
    end
    // Random master cycles across modes, sync settings and waits
    for (i = 0; i < 24; i++)
    begin
      reg_wr(BCH_OFF_CFG, {14'h0, i[1], 1'b0});
      mode <= i[0];
      dma(1'($random(seed)));
      @(negedge clk);
      exp = dwr ? order(dwd) : order(16'hA5C3);
      `CHK(dwr ? seen : drd, exp)
      `CHK(({mwr, aoe, oaddr}), ({dwr, 1'b0, dad}))
    end
    reg_wr(BCH_OFF_STAT, 16'h0007);
    // Retry, plain then latched, with interrupt raise, mask and clear
    for (i = 0; i < 2; i++)
    begin
      reg_wr(BCH_OFF_CFG, {14'h0, 1'b1, i[0]});
      arm <= 1;
      dma(0);
      arm <= 0;
      reg_rd(BCH_OFF_STAT);
      `CHK(q[0], 1'b1)
      `CHK(susp, i[0])
      if (i == 1)
      begin
        @(posedge clk); dreq <= 1;
        repeat (20) begin @(negedge clk); `CHK(strobe, 1'b1) end
        reg_wr(BCH_OFF_MASK, 16'h0001); @(negedge clk); `CHK(irq, 1'b1)
        reg_wr(BCH_OFF_MASK, 16'h0000); @(negedge clk); `CHK(irq, 1'b0)
        reg_wr(BCH_OFF_STAT, 16'h0007);
        wait_on(0);
        `CHK(susp, 1'b0)
      end
      reg_wr(BCH_OFF_STAT, 16'h0007);
    end
    // Slave register cycles in both modes, then a shared memory grant
    own <= 0;
    for (i = 0; i < 4; i++)
    begin
      mode <= i[0];
      @(posedge clk); rw <= i[1]; ra <= 6'($random(seed));
      repeat (2) @(posedge clk);
      sel_n <= 0; ds_n <= 0;
      wait_on(1);
      `CHK(haddr, ra)
      `CHK(hread, mode ? rw : !rw)
      @(posedge clk); hdone <= 1; hrd <= 16'($random(seed)); @(posedge clk); hdone <= 0;
      @(negedge clk);
      `CHK(({shared_acknowledge, mode ? ackl_o : rdy_o, aoe}), 3'b001)
      if (hread) `CHK(({oe, odata}), ({1'b0, order(hrd)}))
      else `CHK(hwd, order(~16'hA5C3))
      @(posedge clk); sel_n <= 1; ds_n <= 1;
      repeat (3) @(posedge clk);
      memory_request_n <= 0;
      repeat (4) @(negedge clk);
      `CHK(({grant, shared_acknowledge}), 2'b10)
      @(posedge clk); memory_request_n <= 1;
      repeat (3) @(posedge clk);
    end
    give_verdict;
  end
endmodule
